// >>> rtl/ide_decode_pkg.sv
// constants for the ide chip select and transceiver decoder
// assumes a host i/o bus with 10 decoded address bits
package ide_decode_pkg;
  localparam int          ADDR_W         = 10;
  localparam logic [9:0]  PRIMARY_BASE   = 10'h1f0;
  localparam logic [9:0]  PRIMARY_MASK   = 10'h3f8;
  localparam logic [9:0]  ALTERNATE_BASE = 10'h3f6;
  localparam logic [9:0]  ALTERNATE_MASK = 10'h3fe;
  localparam int          DMA_ENABLE_BIT = 1;
  localparam int          CFG_W          = 8;
endpackage

// >>> rtl/ide_chip_select_decoder.sv
// ide chip select, transceiver enable and bit-7 path control
// assumes host strobes and drive inputs are asynchronous pins; all outputs are
// registered, so each decision lands two sync stages plus one edge after its pin inputs and one edge after the config word
`timescale 1ns/1ps
module ide_chip_select_decoder
  import ide_decode_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [ide_decode_pkg::ADDR_W-1:0] host_addr,
  input  wire logic                        host_aen,
  input  wire logic                        host_rd_n,
  input  wire logic                        host_wr_n,
  input  wire logic                        host_d7_in,
  input  wire logic                        drive_wide_cycle_n,
  input  wire logic                        drive_bit7_in,
  input  wire logic                        drive_dma_ack_n,
  input  wire logic                        disk_change_in,
  input  wire logic [ide_decode_pkg::CFG_W-1:0] function_config_reg,
  output logic                             primary_drive_select_n,
  output logic                             alternate_drive_select_n,
  output logic                             low_byte_xcvr_enable_n,
  output logic                             high_byte_xcvr_enable_n,
  output logic                             host_d7_out,
  output logic                             host_d7_oe,
  output logic                             drive_bit7_line,
  output logic                             drive_bit7_oe
);
  import ide_decode_pkg::*;

  // the decode tables below are written for a full ten-bit i/o address
  if (ADDR_W != 10)
  begin : g_addr_width
    $error("host address must be ten bits wide");
  end
  if ((PRIMARY_BASE & ~PRIMARY_MASK) != 10'h000)
  begin : g_primary_align
    $error("primary base has bits outside its mask");
  end
  if ((ALTERNATE_BASE & ~ALTERNATE_MASK) != 10'h000)
  begin : g_alternate_align
    $error("alternate base has bits outside its mask");
  end
  // bit 0 must stay open so the alternate block can split 3f6h from 3f7h
  if (ALTERNATE_MASK[0] != 1'b0)
  begin : g_alternate_split
    $error("alternate mask must leave address bit 0 free");
  end
  if ((ALTERNATE_BASE & PRIMARY_MASK) == PRIMARY_BASE)
  begin : g_block_overlap
    $error("alternate block falls inside the primary block");
  end
  if (DMA_ENABLE_BIT >= CFG_W)
  begin : g_cfg_bit
    $error("dma enable bit lies outside the config word");
  end

  // one snapshot of every pin the decode looks at
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              aen;
    logic              rd_n;
    logic              wr_n;
    logic              wide_n;
    logic              ack_n;
    logic              host_d7;
    logic              drive_d7;
    logic              change;
  } pins_t;

  // strobes decoded to active high
  typedef struct packed {
    logic rd;
    logic wr;
    logic any;
    logic wide;
    logic ack;
  } strobe_t;

  typedef struct packed {
    logic pri;
    logic alt;
    logic alt_ctl;
    logic alt_chg;
  } sel_t;

  typedef struct packed {
    logic hd7;
    logic hd7_oe;
    logic dd7;
    logic dd7_oe;
  } b7_t;

  typedef struct packed {
    logic pri_n;
    logic alt_n;
    logic lo_n;
    logic hi_n;
    logic hd7;
    logic hd7_oe;
    logic dd7;
    logic dd7_oe;
  } outs_t;

  // two synchroniser stages and the output register; only sync2 is decoded
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    outs_t outs;
  } state_t;

  // idle pins: strobes and acknowledge high, aen high so nothing selects
  localparam pins_t PINS_IDLE = '{
    addr:     '0,
    aen:      1'b1,
    rd_n:     1'b1,
    wr_n:     1'b1,
    wide_n:   1'b1,
    ack_n:    1'b1,
    host_d7:  1'b0,
    drive_d7: 1'b0,
    change:   1'b0
  };

  localparam outs_t OUTS_IDLE = '{
    pri_n:  1'b1,
    alt_n:  1'b1,
    lo_n:   1'b1,
    hi_n:   1'b1,
    hd7:    1'b0,
    hd7_oe: 1'b0,
    dd7:    1'b0,
    dd7_oe: 1'b0
  };

  state_t s_q;
  state_t s_d;
  pins_t  pins_now;

  function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input logic [ADDR_W-1:0] mask);
    in_block = ((a & mask) == base);
  endfunction

  function automatic strobe_t strobes(input pins_t p);
    strobe_t s;
    s.rd    = ~p.rd_n;
    s.wr    = ~p.wr_n;
    s.any   = ~p.rd_n | ~p.wr_n;
    s.wide  = ~p.wide_n;
    s.ack   = ~p.ack_n;
    strobes = s;
  endfunction

  function automatic sel_t selects(input pins_t p,
                                   input logic  dma_cyc);
    logic io_cyc;
    sel_t s;
    // aen high marks a dma controller cycle, which must never select a drive
    io_cyc    = ~p.aen & ~dma_cyc;
    s.pri     = in_block(p.addr, PRIMARY_BASE, PRIMARY_MASK) & io_cyc;
    s.alt     = in_block(p.addr, ALTERNATE_BASE, ALTERNATE_MASK) & io_cyc;
    s.alt_ctl = s.alt & ~p.addr[0];
    s.alt_chg = s.alt & p.addr[0];
    selects   = s;
  endfunction

  // 3f7h writes leave the low byte shut so the floppy side keeps that address
  function automatic logic low_enable_n(input sel_t    s,
                                        input strobe_t st,
                                        input logic    dma_cyc);
    logic on;
    on = 1'b0;
    if (s.pri && st.any)
    begin
      on = 1'b1;
    end
    if (s.alt_ctl && st.any)
    begin
      on = 1'b1;
    end
    if (s.alt_chg && st.rd)
    begin
      on = 1'b1;
    end
    if (dma_cyc && st.any)
    begin
      on = 1'b1;
    end
    low_enable_n = ~on;
  endfunction

  // the upper byte opens only for a primary cycle the drive flags as wide
  function automatic logic high_enable_n(input sel_t    s,
                                         input strobe_t st);
    logic on;
    on            = s.pri & st.any;
    on            = on & st.wide;
    high_enable_n = ~on;
  endfunction

  function automatic b7_t bit7_path(input pins_t   p,
                                    input sel_t    s,
                                    input strobe_t st,
                                    input logic    dma_cyc);
    logic drive_side;
    b7_t  b;
    // 3f7h is left out: bit 7 there belongs to the floppy change flag
    drive_side = s.pri | s.alt_ctl | dma_cyc;
    b.hd7_oe   = (drive_side & st.rd) | (s.alt_chg & st.rd);
    if (s.alt_chg)
    begin
      b.hd7 = p.change;
    end
    else
    begin
      b.hd7 = p.drive_d7;
    end
    b.dd7_oe  = drive_side & st.wr;
    b.dd7     = p.host_d7;
    bit7_path = b;
  endfunction

  function automatic outs_t decode(input pins_t p,
                                   input logic  dma_on);
    strobe_t st;
    sel_t    s;
    b7_t     b;
    logic    dma_cyc;
    outs_t   o;
    st       = strobes(p);
    // the acknowledge counts only once software has switched dma support on
    dma_cyc  = dma_on & st.ack;
    s        = selects(p, dma_cyc);
    b        = bit7_path(p, s, st, dma_cyc);
    o.pri_n  = ~s.pri;
    o.alt_n  = ~s.alt;
    o.lo_n   = low_enable_n(s, st, dma_cyc);
    o.hi_n   = high_enable_n(s, st);
    o.hd7    = b.hd7;
    o.hd7_oe = b.hd7_oe;
    o.dd7    = b.dd7;
    o.dd7_oe = b.dd7_oe;
    decode   = o;
  endfunction

  // a strobe shorter than one clock period can fall between edges and never reach the outputs
  assign pins_now = '{addr:     host_addr,
                      aen:      host_aen,
                      rd_n:     host_rd_n,
                      wr_n:     host_wr_n,
                      wide_n:   drive_wide_cycle_n,
                      ack_n:    drive_dma_ack_n,
                      host_d7:  host_d7_in,
                      drive_d7: drive_bit7_in,
                      change:   disk_change_in};

  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = pins_now;
    s_d.sync2 = s_q.sync1;
    // the config word is a register of this clock, so it skips the synchroniser
    s_d.outs  = decode(s_q.sync2, function_config_reg[DMA_ENABLE_BIT]);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '{sync1: PINS_IDLE, sync2: PINS_IDLE, outs: OUTS_IDLE};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // every output is a field of the output register, with no logic after it
  assign primary_drive_select_n   = s_q.outs.pri_n;
  assign alternate_drive_select_n = s_q.outs.alt_n;
  assign low_byte_xcvr_enable_n   = s_q.outs.lo_n;
  assign high_byte_xcvr_enable_n  = s_q.outs.hi_n;
  assign host_d7_out              = s_q.outs.hd7;
  assign host_d7_oe               = s_q.outs.hd7_oe;
  assign drive_bit7_line          = s_q.outs.dd7;
  assign drive_bit7_oe            = s_q.outs.dd7_oe;
endmodule

// >>> test/ide_decode_chk.sv
// port assertions for the ide decoder
// assumes every output lags its inputs by three clock edges
`timescale 1ns/1ps
module ide_decode_chk (
  input wire logic clk, reset_n, host_aen, host_rd_n, host_d7_in, drive_dma_ack_n,
  input wire logic drive_wide_cycle_n, drive_bit7_in, primary_drive_select_n,
  input wire logic alternate_drive_select_n, low_byte_xcvr_enable_n, host_d7_oe,
  input wire logic high_byte_xcvr_enable_n, host_d7_out, drive_bit7_line, drive_bit7_oe,
  input wire logic [9:0] host_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence prim_rd;
    !host_rd_n && !host_aen && drive_dma_ack_n && host_addr[9:3] == 7'h3e;
  endsequence
  prim_sel_a: assert property (prim_rd [*4] |-> !primary_drive_select_n)
    else $error("primary select missing");
  aen_block_a: assert property (!primary_drive_select_n |-> !$past(host_aen, 3))
    else $error("select during dma bus cycle");
  alt_sel_a: assert property (!alternate_drive_select_n |->
    $past(host_addr[9:1], 3) == 9'h1fb) else $error("alternate select off block");
  hi_gate_a: assert property (!high_byte_xcvr_enable_n |->
    !primary_drive_select_n && !$past(drive_wide_cycle_n, 3)) else $error("high enable");
  lo_wr_a: assert property ($past(host_rd_n, 3) && $past(host_addr[0], 3) &&
    !alternate_drive_select_n |-> low_byte_xcvr_enable_n) else $error("low enable");
  d7_off_a: assert property (!alternate_drive_select_n && $past(host_addr[0], 3) |->
    !drive_bit7_oe) else $error("bit 7 driven");
  d7_read_a: assert property (host_d7_oe && !primary_drive_select_n |->
    host_d7_out == $past(drive_bit7_in, 3)) else $error("bit 7 read");
  d7_write_a: assert property (drive_bit7_oe |->
    drive_bit7_line == $past(host_d7_in, 3)) else $error("bit 7 write");
endmodule
bind ide_chip_select_decoder ide_decode_chk ide_decode_chk_i (.*);

// >>> test/drive_model.sv
// drive side: bit 7 answer and wide-cycle flag
// assumes the bench commands wide cycles
`timescale 1ns/1ps
module drive_model (input wire logic clk, rd_n, wide, v, output logic wide_n, d7);
  logic tog = 1'h0;
  always @(posedge clk) tog <= ~tog;
  // released line toggles so stale data never matches
  assign d7 = rd_n ? tog : v;
  assign wide_n = ~wide;
endmodule

// >>> test/ide_chip_select_decoder_tb.sv
// bench for the ide decoder
// assumes the drive model on the far side
`timescale 1ns/1ps
module ide_chip_select_decoder_tb;
  logic clk = 1'h0, reset_n = 1'h0, aen, rd_n, wr_n, ack_n, wide, v, wide_n, d7;
  logic [9:0] a;
  logic [7:0] cfg = 8'h00, g;
  wire nv = ~v;
  int n_mismatch = 0, total_checks = 0;
  initial forever #25 clk = ~clk;
  drive_model drive_model_i (.clk, .rd_n, .wide, .v, .wide_n, .d7);
  ide_chip_select_decoder ide_chip_select_decoder_i (.clk, .reset_n, .host_addr(a),
    .host_aen(aen), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_d7_in(nv),
    .drive_wide_cycle_n(wide_n), .drive_bit7_in(d7), .drive_dma_ack_n(ack_n),
    .disk_change_in(nv), .function_config_reg(cfg), .primary_drive_select_n(g[7]),
    .alternate_drive_select_n(g[6]), .low_byte_xcvr_enable_n(g[5]),
    .high_byte_xcvr_enable_n(g[4]), .host_d7_oe(g[3]), .drive_bit7_oe(g[2]),
    .host_d7_out(g[1]), .drive_bit7_line(g[0]));
  task automatic op(input logic [9:0] ad, input logic [6:0] c, input logic [7:0] e);
    @(posedge clk);
    {cfg[1], aen, wide, v, rd_n, wr_n, ack_n, a} <= {c, ad};
    repeat (5) @(posedge clk);
    total_checks++;
    if (g[7:2] !== e[7:2] || (e[3] && g[1] !== e[1]) || (e[2] && g[0] !== e[0]))
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task t_prim;
    op(10'h1f0, 7'h1b, 8'h4a);
    op(10'h1f7, 7'h0d, 8'h54);
    op(10'h1f0, 7'h2b, 8'hf0);
    $display("primary test done");
  endtask
  task t_alt;
    op(10'h3f6, 7'h03, 8'h98);
    op(10'h3f6, 7'h05, 8'h95);
    op(10'h3f7, 7'h03, 8'h9a);
    op(10'h3f7, 7'h05, 8'hb0);
    $display("alternate test done");
  endtask
  task t_dma;
    op(10'h000, 7'h0a, 8'hf0);
    op(10'h000, 7'h44, 8'hd5);
    op(10'h1f0, 7'h4a, 8'hda);
    $display("dma test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {cfg[1], aen, wide, v, rd_n, wr_n, ack_n, a} = 17'h01c00;
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    t_prim;
    t_alt;
    t_dma;
    conclude;
  end
endmodule
